/* bench/dma_channel_sva.sv */
// concurrent checks on the dma channel ports
`timescale 1ns/1ps
`include "dma_chan_consts.vh"
module dma_channel_sva
(
  // clock and reset
  input wire core_clk,
  input wire rst,
  // register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // event, memory and interrupt
  input wire sync_event,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  input wire irq
);
  // ---------
  // shadows of what software wrote
  // ---------
  reg [15:0] ctl, len, sl, sh, dl, dh;
  reg [31:0] rd_val;
  reg evf, req_d;
  wire [31:0] src = {sh, sl};
  wire [31:0] dst = {dh, dl};
  // addresses and length are loaded at enable and at auto restart, modes are read live, so the last write is what runs
  always @(posedge core_clk)
  begin
    if (rst)
      ctl <= 16'h0000;
    else if (reg_wr)
    begin
      case (reg_addr)
        `REG_SRC_LOW: sl <= reg_wdata;
        `REG_SRC_HIGH: sh <= reg_wdata;
        `REG_DST_LOW: dl <= reg_wdata;
        `REG_DST_HIGH: dh <= reg_wdata;
        `REG_LENGTH: len <= reg_wdata;
        `REG_CONTROL: ctl <= reg_wdata;
        default: ;
      endcase
    end
  end
  // last read data and an event-since-last-element flag
  always @(posedge core_clk)
  begin
    if (mem_req && mem_ack && !mem_we)
      rd_val <= mem_rdata;
    req_d <= mem_req;
    evf <= rst ? 1'b0 : (sync_event | (evf & ~(mem_req & ~req_d)));
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_reset_idle: assert property ($fell(rst) |-> !mem_req && !irq)
    else $error("activity right after reset");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we)) else $error("access changed before ack");
  a_read_then_write: assert property (mem_req && mem_ack && !mem_we |=> mem_req && mem_we)
    else $error("read not followed by write");
  a_write_ends: assert property (mem_req && mem_ack && mem_we |=> !mem_req)
    else $error("element longer than one double word");
  a_write_data: assert property (mem_req && mem_we |-> mem_wdata == rd_val)
    else $error("written value differs from read value");
  a_src_const: assert property (mem_req && !mem_we && ctl[7:6] == `AMODE_CONST
    |-> mem_addr == src) else $error("constant source moved");
  a_dst_const: assert property (mem_req && mem_we && ctl[9:8] == `AMODE_CONST
    |-> mem_addr == dst) else $error("constant destination moved");
  a_dst_inc: assert property (mem_req && mem_we && ctl[9:8] == `AMODE_INC |->
    (mem_addr - dst) < {16'h0000, len} && mem_addr[1:0] == dst[1:0])
    else $error("destination outside block");
  a_one_per_event: assert property ($rose(mem_req) && ctl[2] && ctl[5:3] == 3'h0
    |-> evf) else $error("element without event");
  a_irq_masked: assert property (reg_wr && reg_addr == `REG_IRQ_MASK
    && reg_wdata[1:0] == 2'h0 |=> !irq) else $error("masked interrupt high");
  c_burst: cover property (sync_event ##[1:20] mem_we && ctl[5:3] == 3'h3);
  c_irq: cover property ($rose(irq));
  c_slow: cover property (mem_req && !mem_ack [*2]);
endmodule // dma_channel_sva
bind dma_channel dma_channel_sva u_dma_channel_sva (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sync_event(sync_event), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
  .mem_ack(mem_ack), .irq(irq));

/* bench/mem_model.sv */
// memory and peripheral model answering the channel's accesses
`timescale 1ns/1ps
module mem_model
(
  // clock and reset
  input wire core_clk,
  input wire rst,
  // pace chosen by the bench
  input wire slow,
  // access port
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  output reg [31:0] mem_rdata = 32'h0000_0000,
  output reg mem_ack
);
  logic [31:0] wa[$];
  logic [31:0] wd[$];
  reg [15:0] seq;
  int cnt;
  // ---------
  // one answer per access, after a random wait when slow
  // ---------
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      mem_ack <= 1'b0;
      seq <= 16'h0000;
      cnt <= 0;
    end
    else if (mem_ack)
    begin
      // read data is not held once taken
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt <= slow ? $urandom_range(3, 1) : 0;
    end
    else if (mem_req && cnt != 0)
      cnt <= cnt - 1;
    else if (mem_req)
    begin
      mem_ack <= 1'b1;
      if (mem_we)
      begin
        wa.push_back(mem_addr);
        wd.push_back(mem_wdata);
      end
      else
      begin
        // every double-word read pops one fresh sample
        mem_rdata <= {seq, mem_addr[15:0]};
        seq <= seq + 16'h0001;
      end
    end
  end
endmodule // mem_model

/* bench/tb_top.sv */
// self-checking testbench for one dma channel
`timescale 1ns/1ps
`include "dma_chan_consts.vh"
module tb_top;
  // ---------
  // stimulus, design and partner
  // ---------
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg sync_event = 1'b0;
  reg slow = 1'b0;
  wire [15:0] reg_rdata;
  wire mem_req, mem_we, mem_ack, irq;
  wire [31:0] mem_addr, mem_wdata, mem_rdata;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int nel = 0;
  int k;
  logic [15:0] v, w16;
  always #4 core_clk = ~core_clk;
  dma_channel u_dma_channel (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_event(sync_event), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));
  mem_model u_mem_model (.core_clk(core_clk), .rst(rst), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  task end_sim;
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task waitn(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one peripheral event, then time for a single element to land
  task ev;
    @(posedge core_clk);
    sync_event <= 1'b1;
    @(posedge core_clk);
    sync_event <= 1'b0;
    waitn(30);
  endtask
  // strobes lead with an edge so no signal is driven twice in a step
  task wr(input [3:0] a, input [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a, output [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic [31:0] exp_addr(input [31:0] base, input [1:0] mode, input int i);
    exp_addr = mode == `AMODE_INC ? base + 32'(4 * i) : base;
  endfunction
  // program, pace with events if synced, then check every element
  task xfer(input [15:0] ctl, input [15:0] len);
    logic [31:0] src, dst, a;
    int w, b, i, j, s0;
    src = $urandom & 32'h000f_fffc;
    dst = $urandom & 32'h000f_fffc;
    w = len / 4;
    b = 1 << ctl[5:3];
    s0 = nel;
    u_mem_model.wa.delete();
    u_mem_model.wd.delete();
    wr(`REG_SRC_LOW, src[15:0]);
    wr(`REG_SRC_HIGH, src[31:16]);
    wr(`REG_DST_LOW, dst[15:0]);
    wr(`REG_DST_HIGH, dst[31:16]);
    wr(`REG_LENGTH, len);
    wr(`REG_CONTROL, ctl);
    if (ctl[`CTL_SYNC])
    begin
      waitn(20);
      chk("no event", 0, u_mem_model.wa.size());
      for (j = b; j <= w; j += b)
      begin
        @(posedge core_clk);
        sync_event <= 1'b1;
        @(posedge core_clk);
        sync_event <= 1'b0;
        for (i = 0; i < 400 && u_mem_model.wa.size() < j; i++) @(posedge core_clk);
        waitn(20);
        chk("per event", j, u_mem_model.wa.size());
      end
    end
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge core_clk);
    chk("irq", 1, irq);
    chk("count", w, u_mem_model.wa.size());
    for (i = 0; i < w; i++)
    begin
      a = exp_addr(src, ctl[7:6], i);
      chk("dst addr", exp_addr(dst, ctl[9:8], i), u_mem_model.wa[i]);
      chk("data", {s0[15:0] + i[15:0], a[15:0]}, u_mem_model.wd[i]);
    end
    nel += w;
    rd(`REG_CONTROL, v);
    chk("ctl done", ctl & 16'h3fff, v);
    rd(`REG_IRQ_STATUS, v);
    chk("status", 16'h0001, v);
    wr(`REG_IRQ_MASK, 16'h0000);
    #1 chk("masked", 0, irq);
    wr(`REG_IRQ_MASK, 16'h0003);
    #1 chk("unmasked", 1, irq);
    wr(`REG_IRQ_STATUS, 16'h0001);
    #1 chk("cleared", 0, irq);
  endtask
  // a hang ends the run as a failure
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count++;
      end_sim;
    end
  end
  initial
  begin
    void'($urandom(32'h2393));
    waitn(4);
    rst <= 1'b0;
    // all registers clear, unmapped places read zero
    for (k = 0; k < 10; k++)
    begin
      rd(k[3:0], v);
      chk("reset", 0, v);
    end
    wr(4'hb, 16'hffff);
    rd(4'hb, v);
    chk("unmapped", 0, v);
    w16 = $urandom & 16'h7fff;
    wr(`REG_CONTROL, w16);
    rd(`REG_CONTROL, v);
    chk("ctl rb", w16 & 16'h33fd, v);
    wr(`REG_IRQ_MASK, 16'h0003);
    // free block moves, the memory pace alternating
    for (k = 0; k < 4; k++)
    begin
      slow <= k[0];
      xfer(16'ha000, 16'(4 * $urandom_range(1, 16)));
    end
    xfer(16'ha280, 16'h0004);
    // event paced service, every burst size up to sixteen
    for (k = 0; k < 5; k++)
    begin
      slow <= k[0];
      xfer(16'ha084 | 16'(k << 3), 16'(8 << k));
    end
    // auto restart with ping-pong halves, then software stops the channel
    u_mem_model.wa.delete();
    wr(`REG_DST_LOW, 16'h0100);
    wr(`REG_DST_HIGH, 16'h0000);
    wr(`REG_LENGTH, 16'h0008);
    wr(`REG_CONTROL, 16'hb085);
    ev;
    ev;
    rd(`REG_IRQ_STATUS, v);
    chk("half and done", 16'h0003, v);
    rd(`REG_CONTROL, v);
    chk("still running", 16'hf087, v);
    ev;
    chk("second addr", 32'h0000_0104, u_mem_model.wa[1]);
    chk("reload addr", 32'h0000_0100, u_mem_model.wa[2]);
    wr(`REG_CONTROL, 16'h0000);
    ev;
    chk("stopped", 3, u_mem_model.wa.size());
    rd(`REG_CONTROL, v);
    chk("flag kept", 16'h0002, v);
    wr(`REG_IRQ_STATUS, 16'h0003);
    end_sim;
  end
endmodule // tb_top

/* design/dma_chan_consts.vh */
// register map, field positions and reset values for one dma channel
`ifndef DMA_CHAN_CONSTS_VH
`define DMA_CHAN_CONSTS_VH
// register indices on the local register port
`define REG_SRC_LOW 4'h0
`define REG_SRC_HIGH 4'h1
`define REG_DST_LOW 4'h2
`define REG_DST_HIGH 4'h3
`define REG_LENGTH 4'h4
`define REG_CONTROL 4'h5
`define REG_IRQ_STATUS 4'h6
`define REG_IRQ_MASK 4'h7
// control register fields
`define CTL_EN 15
`define CTL_STATUS 14
`define CTL_IRQ_EN 13
`define CTL_AUTO 12
`define CTL_DMODE_HI 9
`define CTL_DMODE_LO 8
`define CTL_SMODE_HI 7
`define CTL_SMODE_LO 6
`define CTL_BURST_HI 5
`define CTL_BURST_LO 3
`define CTL_SYNC 2
`define CTL_HALF 1
`define CTL_PINGPONG 0
// address mode codes
`define AMODE_INC 2'h0
`define AMODE_CONST 2'h2
// reset values
`define RST_CONTROL 16'h0000
`define RST_WORD16 16'h0000
`define RST_IRQ 2'h0
// interrupt status bits
`define IRQ_BLOCK_DONE 0
`define IRQ_HALF_DONE 1
// bytes per double word
`define BYTES_PER_XFER 16'h0004
`endif

/* design/dma_channel.v */
// one dma channel: registers, event pacing, address update and completion
//
// Function
// R1: the channel does free-running block moves and event-paced peripheral service.
// R2: address mode 10b holds an address constant and 00b post-increments it per access.
// R3: each receive event from a single-sample peripheral moves one whole double word.
// R4: with sync on and single-transfer burst, one element moves per event, then it waits.
// R5: in burst mode a whole burst moves per event; software matches it to the fifo trigger.
// R6: every access is a double word, so each byte sample fills four destination bytes.
// R7: the peripheral presents data together with its event, one or several per event.
// R8: transmit and receive streams use separate channel instances with own settings.
// R9: start addresses are byte addresses in the dma space.
// R10: the 16-bit control register has enable 15, status 14, irq 13, reload 12, modes etc.
// R11: the length register holds a byte count, four per double word.
// R12: each sample is written as 32 bits, two 16-bit words, before the address moves on.
// R13: once set up the channel keeps servicing without processor help per transfer.
// R14: with sync the channel waits for its event; without it starts on enable.
// R15: at block end enable and status clear and an interrupt rises when enabled; with auto restart on, enable and status stay set.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "dma_chan_consts.vh"
module dma_channel
(
  // clock and reset
  input wire core_clk,
  input wire rst,
  // register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // synchronization event from the serviced peripheral
  input wire sync_event,
  // memory port
  output wire mem_req,
  output wire mem_we,
  output wire [31:0] mem_addr,
  output wire [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  // interrupt
  output wire irq
);

  localparam CH_IDLE = 2'h0;
  localparam CH_WAIT = 2'h1;
  localparam CH_MOVE = 2'h2;
  localparam CH_NEXT = 2'h3;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [15:0] source_start_low;
  reg [15:0] source_start_high;
  reg [15:0] dest_start_low;
  reg [15:0] dest_start_high;
  reg [15:0] channel_length_reg;
  reg [15:0] channel_transfer_control;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;

  reg [1:0] state;
  reg [31:0] cur_src;
  reg [31:0] cur_dst;
  reg [15:0] bytes_left;
  reg [15:0] bytes_done;
  reg [7:0] burst_left;
  reg event_pending;
  reg mover_start;
  reg set_done;
  reg set_half;
  reg clear_run;
  reg flip_half;

  wire mover_busy;
  wire mover_done;
  wire enabled = channel_transfer_control[`CTL_EN];
  wire sync_on = channel_transfer_control[`CTL_SYNC];
  wire ping_pong = channel_transfer_control[`CTL_PINGPONG];
  wire auto_restart = channel_transfer_control[`CTL_AUTO];
  wire cpu_irq_enable = channel_transfer_control[`CTL_IRQ_EN];
  wire [1:0] src_addr_mode = channel_transfer_control[`CTL_SMODE_HI:`CTL_SMODE_LO];
  wire [1:0] dest_addr_mode = channel_transfer_control[`CTL_DMODE_HI:`CTL_DMODE_LO];
  wire [2:0] burst_length_sel = channel_transfer_control[`CTL_BURST_HI:`CTL_BURST_LO];
  wire [31:0] src_start = {source_start_high, source_start_low}; // byte address [R9]
  wire [31:0] dst_start = {dest_start_high, dest_start_low}; // byte address [R9]
  // burst code n gives 2^n double words; code 0 is one element per event
  wire [7:0] burst_words = 8'h01 << burst_length_sel; // [R5]
  wire [15:0] half_len = {1'b0, channel_length_reg[15:1]};
  wire [15:0] next_bytes_done = bytes_done + `BYTES_PER_XFER;
  wire en_write = reg_wr && (reg_addr == `REG_CONTROL) && reg_wdata[`CTL_EN];

  // ------------------------------------------------------------
  // transfer engine, one double word per request
  // ------------------------------------------------------------
  dma_mover u_mover
  (
    .core_clk(core_clk),
    .rst(rst),
    .start(mover_start),
    .src_addr(cur_src),
    .dst_addr(cur_dst),
    .busy(mover_busy),
    .done(mover_done),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack)
  );

  // ------------------------------------------------------------
  // channel sequencer
  // ------------------------------------------------------------
  // an event seen while a burst is in flight is kept, not dropped
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= CH_IDLE;
      cur_src <= 32'h0000_0000;
      cur_dst <= 32'h0000_0000;
      bytes_left <= 16'h0000;
      bytes_done <= 16'h0000;
      burst_left <= 8'h00;
      event_pending <= 1'b0;
      mover_start <= 1'b0;
      set_done <= 1'b0;
      set_half <= 1'b0;
      clear_run <= 1'b0;
      flip_half <= 1'b0;
    end
    else
    begin
      mover_start <= 1'b0;
      set_done <= 1'b0;
      set_half <= 1'b0;
      clear_run <= 1'b0;
      flip_half <= 1'b0;
      if (sync_event && enabled && sync_on)
        event_pending <= 1'b1; // [R7]
      case (state)
        CH_IDLE:
        begin
          if (en_write)
          begin
            cur_src <= src_start;
            cur_dst <= dst_start;
            bytes_left <= channel_length_reg; // byte count [R11]
            bytes_done <= 16'h0000;
            event_pending <= 1'b0;
            state <= CH_WAIT;
          end
        end
        CH_WAIT:
        begin
          if (!enabled)
            state <= CH_IDLE;
          else if (bytes_left == 16'h0000)
            state <= CH_NEXT;
          else if ((!sync_on || event_pending) && !mover_busy) // [R1] [R14]
          begin
            // an event landing in this very cycle counts for the next burst
            event_pending <= sync_event && sync_on;
            burst_left <= sync_on ? burst_words : 8'h01; // per event [R4] [R5]
            mover_start <= 1'b1;
            state <= CH_MOVE;
          end
        end
        CH_MOVE:
        begin
          if (mover_done)
          begin
            // each sample is 32 bits, the address moves by four bytes [R6] [R12]
            if (src_addr_mode == `AMODE_INC)
              cur_src <= cur_src + 32'h0000_0004; // [R2]
            if (dest_addr_mode == `AMODE_INC)
              cur_dst <= cur_dst + 32'h0000_0004; // constant code 10b holds it [R2]
            bytes_left <= bytes_left - `BYTES_PER_XFER;
            bytes_done <= next_bytes_done;
            if (ping_pong && next_bytes_done == half_len)
              set_half <= 1'b1;
            if (bytes_left == `BYTES_PER_XFER)
              state <= CH_NEXT;
            else if (burst_left > 8'h01)
            begin
              burst_left <= burst_left - 8'h01;
              mover_start <= 1'b1;
            end
            else
              state <= CH_WAIT; // wait for the next event when sync is on [R3] [R4]
          end
        end
        CH_NEXT:
        begin
          set_done <= 1'b1; // [R15]
          flip_half <= ping_pong;
          if (auto_restart) // keeps running without the processor [R13]
          begin
            cur_src <= src_start;
            cur_dst <= dst_start;
            bytes_left <= channel_length_reg;
            bytes_done <= 16'h0000;
            state <= CH_WAIT;
          end
          else
          begin
            clear_run <= 1'b1;
            state <= CH_IDLE;
          end
        end
        default:
          state <= CH_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // register writes and status
  // ------------------------------------------------------------
  // completion without auto restart clears enable and status so software can poll [R15]
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      source_start_low <= `RST_WORD16;
      source_start_high <= `RST_WORD16;
      dest_start_low <= `RST_WORD16;
      dest_start_high <= `RST_WORD16;
      channel_length_reg <= `RST_WORD16;
      channel_transfer_control <= `RST_CONTROL;
      irq_mask <= `RST_IRQ;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `REG_SRC_LOW: source_start_low <= reg_wdata;
          `REG_SRC_HIGH: source_start_high <= reg_wdata;
          `REG_DST_LOW: dest_start_low <= reg_wdata;
          `REG_DST_HIGH: dest_start_high <= reg_wdata;
          `REG_LENGTH: channel_length_reg <= reg_wdata;
          `REG_CONTROL: channel_transfer_control <= {reg_wdata[15], reg_wdata[15],
            reg_wdata[13:12], 2'b00, reg_wdata[9:2], channel_transfer_control[1],
            reg_wdata[0]}; // field layout [R10]
          `REG_IRQ_MASK: irq_mask <= reg_wdata[1:0];
          default: ;
        endcase
      end
      if (flip_half)
        channel_transfer_control[`CTL_HALF] <= ~channel_transfer_control[`CTL_HALF];
      if (clear_run)
      begin
        channel_transfer_control[`CTL_EN] <= 1'b0;
        channel_transfer_control[`CTL_STATUS] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt status, set wins over a write-one clear
  // ------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (rst)
      irq_status <= `RST_IRQ;
    else
    begin
      irq_status <= (irq_status &
        ~((reg_wr && reg_addr == `REG_IRQ_STATUS) ? reg_wdata[1:0] : 2'b00)) |
        {set_half & cpu_irq_enable, set_done & cpu_irq_enable}; // [R15]
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ------------------------------------------------------------
  // read port, data in the cycle after the strobe
  // ------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `REG_SRC_LOW: reg_rdata <= source_start_low;
        `REG_SRC_HIGH: reg_rdata <= source_start_high;
        `REG_DST_LOW: reg_rdata <= dest_start_low;
        `REG_DST_HIGH: reg_rdata <= dest_start_high;
        `REG_LENGTH: reg_rdata <= channel_length_reg;
        `REG_CONTROL: reg_rdata <= channel_transfer_control;
        `REG_IRQ_STATUS: reg_rdata <= {14'h0000, irq_status};
        `REG_IRQ_MASK: reg_rdata <= {14'h0000, irq_mask};
        default: reg_rdata <= 16'h0000; // unmapped reads zero
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // a second stream of the same peripheral needs a second instance, with its own
  // count, mode and burst registers, since nothing here is shared [R8]

endmodule // dma_channel

/* design/dma_mover.v */
// one double-word read-then-write engine on the memory port
`timescale 1ns/1ps
module dma_mover
(
  // clock and reset
  input wire core_clk,
  input wire rst,
  // request from the channel
  input wire start,
  input wire [31:0] src_addr,
  input wire [31:0] dst_addr,
  output wire busy,
  output reg done,
  // memory port, one read and one write per request
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack
);

  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_WRITE = 2'h2;

  reg [1:0] state;
  reg [31:0] dst_hold;

  assign busy = (state != ST_IDLE);

  // read the source word then write the same 32 bits to the destination
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      done <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      dst_hold <= 32'h0000_0000;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (start)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= src_addr;
            dst_hold <= dst_addr;
            state <= ST_READ;
          end
        end
        ST_READ:
        begin
          if (mem_ack)
          begin
            mem_we <= 1'b1;
            mem_addr <= dst_hold;
            mem_wdata <= mem_rdata; // full double word, even from a byte peripheral
            state <= ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          mem_req <= 1'b0;
        end
      endcase
    end
  end

endmodule // dma_mover
